// file: core/hcr_regs.sv
// Host configuration register banks: station address, internal bus
// speed, serial ROM control, memory self-test info and soft reset.
// Assumes the host bus unit has already decoded base and bank.
`timescale 1ns/1ps
`include "hcr_defines.svh"
module hcr_regs #(
  parameter int ROM_HALF_CYC = `HCR_ROM_HALF_CYC
) (
  input wire logic ref_clk_i,               // Clock, 10 MHz
  input wire logic rst_n_i,                 // Async reset, active low
  input wire logic clk_en_i,                // Clock enable
  input wire hcr_pkg::hcr_req_s req_i,      // Host register request
  output hcr_pkg::hcr_word_t rdata_o,       // Read data, registered
  input wire logic rom_present_strap_i,     // ROM fitted strap
  input wire logic rom_data_in_pin_i,       // ROM serial data in pin
  output logic rom_data_out_pin_o,          // ROM serial data out
  output logic rom_serial_clock_pin_o,      // ROM serial clock
  output logic rom_chip_select_pin_o,       // ROM chip select
  input wire hcr_pkg::hcr_selftest_s selftest_i, // Memory self-test status
  output hcr_pkg::hcr_word_t station_addr_low_word_o,  // Station address low
  output hcr_pkg::hcr_word_t station_addr_mid_word_o,  // Station address middle
  output hcr_pkg::hcr_word_t station_addr_high_word_o, // Station address high
  output hcr_pkg::hcr_word_t base_addr_o,   // Chip base address
  output hcr_pkg::hcr_speed_e internal_bus_speed_code_o, // Bus speed select
  output logic core_soft_reset_o,           // Reset to PHY, MAC, queue, DMA, switch
  output logic load_busy_o                  // Post-reset ROM load running
);
  import hcr_pkg::*;

  typedef enum logic [2:0] {
    HCR_L_STRAP,
    HCR_L_ISSUE,
    HCR_L_WAIT,
    HCR_L_IDLE
  } hcr_load_e;

  if (ROM_HALF_CYC < 1) begin : g_half_check
    $error("ROM_HALF_CYC must be at least one");
  end

  hcr_word_t addr_low_r, addr_mid_r, addr_high_r, base_r;
  hcr_speed_e speed_r;
  logic rom_sw_en_r;
  logic [2:0] rom_bits_r;
  logic soft_rst_r;
  hcr_word_t rdata_r;
  hcr_load_e load_r;
  logic [2:0] step_r;
  logic rom_start_r;
  logic [2:0] settle_r;

  logic din_sync;
  logic strap_sync;
  hcr_rom_pins_s ld_pins;
  logic ld_busy;
  logic ld_done;
  hcr_word_t ld_data;

  hcr_sync3 u_sync_din (
    .ref_clk_i(ref_clk_i),
    .rst_n_i(rst_n_i),
    .clk_en_i(clk_en_i),
    .pin_i(rom_data_in_pin_i),
    .level_o(din_sync)
  );

  hcr_sync3 u_sync_strap (
    .ref_clk_i(ref_clk_i),
    .rst_n_i(rst_n_i),
    .clk_en_i(clk_en_i),
    .pin_i(rom_present_strap_i),
    .level_o(strap_sync)
  );

  hcr_rom_reader #(
    .HALF_CYC(ROM_HALF_CYC)
  ) u_reader (
    .ref_clk_i(ref_clk_i),
    .rst_n_i(rst_n_i),
    .clk_en_i(clk_en_i),
    .start_i(rom_start_r),
    .addr_i(step_loc(step_r)),
    .din_i(din_sync),
    .pins_o(ld_pins),
    .busy_o(ld_busy),
    .done_o(ld_done),
    .data_o(ld_data)
  );

  // Load sequence order: base, low, mid, high, config word
  function automatic logic [5:0] step_loc(input logic [2:0] s);
    unique case (s)
      3'h0: step_loc = `HCR_ROM_LOC_BASE;
      3'h1: step_loc = `HCR_ROM_LOC_LOW;
      3'h2: step_loc = `HCR_ROM_LOC_MID;
      3'h3: step_loc = `HCR_ROM_LOC_HIGH;
      default: step_loc = `HCR_ROM_LOC_CFG;
    endcase
  endfunction

  // Register decode
  wire in_addr_bank = (req_i.bank == `HCR_BANK_ADDR);
  wire in_ctrl_bank = (req_i.bank == `HCR_BANK_CTRL);
  wire sel_low = in_addr_bank && (req_i.ofs == `HCR_OFS_ADDR_LOW);
  wire sel_mid = in_addr_bank && (req_i.ofs == `HCR_OFS_ADDR_MID);
  wire sel_high = in_addr_bank && (req_i.ofs == `HCR_OFS_ADDR_HIGH);
  wire sel_speed = in_ctrl_bank && (req_i.ofs == `HCR_OFS_BUS_SPEED);
  wire sel_rom = in_ctrl_bank && (req_i.ofs == `HCR_OFS_ROM_CTRL);
  wire sel_test = in_ctrl_bank && (req_i.ofs == `HCR_OFS_SELFTEST);
  wire sel_srst = in_ctrl_bank && (req_i.ofs == `HCR_OFS_SOFT_RST);

  wire loading = (load_r != HCR_L_IDLE);
  wire ld_word_done = (load_r == HCR_L_WAIT) && ld_done;

  // Host writes are ignored while the loader fills the registers
  wire wr_ok = req_i.wr && !loading;

  // bit 3 reads synchronised data pin
  wire hcr_word_t rom_ctrl_view = {11'h000, rom_sw_en_r, din_sync, rom_bits_r};
  wire hcr_word_t test_view = {3'h0, selftest_i.tx_done, selftest_i.tx_fail, 6'h00,
                               selftest_i.rx_done, selftest_i.rx_fail, 3'h0};

  wire hcr_word_t rd_mux = sel_low ? addr_low_r :
                           sel_mid ? addr_mid_r :
                           sel_high ? addr_high_r :
                           sel_speed ? {14'h0000, speed_r} :
                           sel_rom ? rom_ctrl_view :
                           sel_test ? test_view :
                           sel_srst ? {15'h0000, soft_rst_r} :
                           16'h0000;

  // strap high starts load after reset
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      load_r <= HCR_L_STRAP;
      step_r <= 3'h0;
      rom_start_r <= 1'b0;
    end else if (clk_en_i) begin
      rom_start_r <= 1'b0;
      unique case (load_r)
        HCR_L_STRAP: begin
          // Deciding earlier would read the synchroniser's reset value
          if (settle_r == `HCR_STRAP_SETTLE) begin
            load_r <= strap_sync ? HCR_L_ISSUE : HCR_L_IDLE;
          end
        end
        HCR_L_ISSUE: begin
          rom_start_r <= 1'b1;
          load_r <= HCR_L_WAIT;
        end
        HCR_L_WAIT: begin
          if (ld_done) begin
            step_r <= step_r + 3'h1;
            load_r <= (step_r == 3'h4) ? HCR_L_IDLE : HCR_L_ISSUE;
          end
        end
        HCR_L_IDLE: begin
          load_r <= HCR_L_IDLE;
        end
      endcase
    end
  end

  // Strap sync output is valid only from the fourth edge after release
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      settle_r <= 3'h0;
    end else if (clk_en_i && settle_r != `HCR_STRAP_SETTLE) begin
      settle_r <= settle_r + 3'h1;
    end
  end

  // station address words, loaded from ROM
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      addr_low_r <= `HCR_WORD_RST;
      addr_mid_r <= `HCR_WORD_RST;
      addr_high_r <= `HCR_WORD_RST;
    end else if (clk_en_i) begin
      if (ld_word_done && step_r == 3'h1) addr_low_r <= ld_data;
      else if (wr_ok && sel_low) addr_low_r <= req_i.wdata;
      if (ld_word_done && step_r == 3'h2) addr_mid_r <= ld_data;
      else if (wr_ok && sel_mid) addr_mid_r <= req_i.wdata;
      if (ld_word_done && step_r == 3'h3) addr_high_r <= ld_data;
      else if (wr_ok && sel_high) addr_high_r <= req_i.wdata;
    end
  end

  // base lives with the bus unit, never soft reset
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      base_r <= `HCR_BASE_RST;
    end else if (clk_en_i && ld_word_done && step_r == 3'h0) begin
      base_r <= {ld_data[15:5], 5'h00};
    end
  end

  // config bit 1 picks 00 or 11
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      speed_r <= hcr_speed_e'(`HCR_SPEED_RST);
    end else if (clk_en_i) begin
      if (ld_word_done && step_r == 3'h4) begin
        speed_r <= ld_data[`HCR_CFG_SPEED_BIT] ? hcr_speed_e'(`HCR_SPEED_SLOW)
                                               : hcr_speed_e'(`HCR_SPEED_RST);
      end else if (wr_ok && sel_speed) begin
        speed_r <= hcr_speed_e'(req_i.wdata[1:0]);
      end
    end
  end

  // soft reset bit held by host
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rom_sw_en_r <= 1'b0;
      rom_bits_r <= 3'h0;
      soft_rst_r <= 1'b0;
    end else if (clk_en_i) begin
      if (wr_ok && sel_rom) begin
        rom_sw_en_r <= req_i.wdata[`HCR_ROM_SW_EN_BIT];
        rom_bits_r <= req_i.wdata[2:0];
      end
      if (wr_ok && sel_srst) soft_rst_r <= req_i.wdata[0];
    end
  end

  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rdata_r <= 16'h0000;
    end else if (clk_en_i && req_i.rd) begin
      rdata_r <= rd_mux;
    end
  end

  // loader owns pins unless software enabled
  // software toggles pins directly, no timing added
  wire sw_pins = rom_sw_en_r && !loading;
  assign rom_data_out_pin_o = sw_pins ? rom_bits_r[2] : ld_pins.dout;
  assign rom_serial_clock_pin_o = sw_pins ? rom_bits_r[1] : ld_pins.sk;
  assign rom_chip_select_pin_o = sw_pins ? rom_bits_r[0] : ld_pins.cs;

  assign rdata_o = rdata_r;
  assign station_addr_low_word_o = addr_low_r;
  assign station_addr_mid_word_o = addr_mid_r;
  assign station_addr_high_word_o = addr_high_r;
  assign base_addr_o = base_r;
  assign internal_bus_speed_code_o = speed_r;
  // soft reset reaches the core only
  assign core_soft_reset_o = soft_rst_r;
  assign load_busy_o = loading || ld_busy;
endmodule

// file: inc/hcr_defines.svh
// Offsets, field positions, reset values and timing counts for the host
// configuration register banks. Assumes a 16-bit register word.
`ifndef HCR_DEFINES_SVH
`define HCR_DEFINES_SVH

// Bank numbers reached through the host's bank select
`define HCR_BANK_ADDR 2'h2
`define HCR_BANK_CTRL 2'h3

// Register offsets inside a bank (byte offsets, word aligned)
`define HCR_OFS_ADDR_LOW 3'h0
`define HCR_OFS_ADDR_MID 3'h2
`define HCR_OFS_ADDR_HIGH 3'h4
`define HCR_OFS_BUS_SPEED 3'h0
`define HCR_OFS_ROM_CTRL 3'h2
`define HCR_OFS_SELFTEST 3'h4
`define HCR_OFS_SOFT_RST 3'h6

// Field positions
`define HCR_ROM_SW_EN_BIT 4
`define HCR_ROM_DIN_BIT 3
`define HCR_TX_DONE_BIT 12
`define HCR_TX_FAIL_BIT 11
`define HCR_RX_DONE_BIT 4
`define HCR_RX_FAIL_BIT 3
`define HCR_CFG_SPEED_BIT 1

// Reset values and the slow speed code
`define HCR_SPEED_RST 2'h0
`define HCR_SPEED_SLOW 2'h3
`define HCR_BASE_RST 16'h0300
`define HCR_WORD_RST 16'h0000

// Serial ROM word locations loaded after reset
`define HCR_ROM_LOC_BASE 6'h00
`define HCR_ROM_LOC_LOW 6'h01
`define HCR_ROM_LOC_MID 6'h02
`define HCR_ROM_LOC_HIGH 6'h03
`define HCR_ROM_LOC_CFG 6'h06

// Edges after reset release before the strap synchroniser output is trusted
`define HCR_STRAP_SETTLE 3'h4

// Serial ROM clock: least half period 1000 ns at 10 MHz (100 ns)
`define HCR_CLK_PERIOD_NS 100
`define HCR_ROM_HALF_NS 1000
`define HCR_ROM_HALF_CYC ((`HCR_ROM_HALF_NS + `HCR_CLK_PERIOD_NS - 1) / `HCR_CLK_PERIOD_NS)

`endif

// file: inc/hcr_pkg.sv
// Types shared by the host configuration register banks.
// Assumes hcr_defines.svh is compiled alongside.
package hcr_pkg;

  typedef logic [15:0] hcr_word_t;

  // Host register access
  typedef struct packed {
    logic       rd;
    logic       wr;
    logic [1:0] bank;
    logic [2:0] ofs;
    hcr_word_t  wdata;
  } hcr_req_s;

  // Serial ROM pins driven by the block
  typedef struct packed {
    logic cs;
    logic sk;
    logic dout;
  } hcr_rom_pins_s;

  // Self-test status from the buffer memories
  typedef struct packed {
    logic tx_done;
    logic tx_fail;
    logic rx_done;
    logic rx_fail;
  } hcr_selftest_s;

  typedef enum logic [1:0] {
    HCR_SPD_125,
    HCR_SPD_62P5,
    HCR_SPD_41P66,
    HCR_SPD_25
  } hcr_speed_e;

endpackage

// file: core/hcr_sync3.sv
// Three-stage synchroniser for a pin level; the output changes once
// stages two and three agree. Assumes one clock and a clock enable.
`timescale 1ns/1ps
module hcr_sync3 (
  input wire logic ref_clk_i, // Clock
  input wire logic rst_n_i,   // Async reset, active low
  input wire logic clk_en_i,  // Clock enable
  input wire logic pin_i,     // Asynchronous pin level
  output logic level_o        // Filtered level
);
  logic [2:0] stage_r;
  logic level_r;

  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      stage_r <= 3'h0;
      level_r <= 1'b0;
    end else if (clk_en_i) begin
      stage_r <= {stage_r[1:0], pin_i};
      if (stage_r[1] == stage_r[2]) begin
        level_r <= stage_r[2];
      end
    end
  end

  assign level_o = level_r;
endmodule

// file: core/hcr_rom_reader.sv
// Microwire-style serial ROM word reader used by the post-reset loader.
// Assumes a part organised as 64 x 16 with start bit 1 and READ opcode 10.
`timescale 1ns/1ps
`include "hcr_defines.svh"
module hcr_rom_reader #(
  parameter int HALF_CYC = `HCR_ROM_HALF_CYC
) (
  input wire logic ref_clk_i,          // Clock
  input wire logic rst_n_i,            // Async reset, active low
  input wire logic clk_en_i,           // Clock enable
  input wire logic start_i,            // Start one word read, pulse
  input wire logic [5:0] addr_i,       // Word location
  input wire logic din_i,              // Synchronised serial data in
  output hcr_pkg::hcr_rom_pins_s pins_o, // Serial ROM pins
  output logic busy_o,                 // Read in progress
  output logic done_o,                 // Word ready, pulse
  output hcr_pkg::hcr_word_t data_o    // Word read
);
  import hcr_pkg::*;

  // Tick counter is 16 bits wide
  if (HALF_CYC < 1 || HALF_CYC > 65535) begin : g_half_check
    $error("HALF_CYC out of range");
  end

  // 1 start + 2 opcode + 6 address + 1 dummy zero + 16 data
  localparam logic [5:0] LAST_BIT = 6'd25;

  logic [15:0] tick_r;
  logic [5:0] bit_r;
  logic [8:0] cmd_r;
  hcr_word_t data_r;
  hcr_rom_pins_s pins_r;
  logic busy_r;
  logic done_r;

  wire tick_end = (tick_r == 16'(HALF_CYC - 1));
  wire rise = tick_end && !pins_r.sk;
  wire fall = tick_end && pins_r.sk;

  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      tick_r <= 16'h0000;
      bit_r <= 6'h00;
      cmd_r <= 9'h000;
      data_r <= 16'h0000;
      pins_r <= '0;
      busy_r <= 1'b0;
      done_r <= 1'b0;
    end else if (clk_en_i) begin
      done_r <= 1'b0;
      if (!busy_r) begin
        tick_r <= 16'h0000;
        if (start_i) begin
          busy_r <= 1'b1;
          bit_r <= 6'h00;
          // Start bit leaves now; opcode, address and a trailing zero follow
          cmd_r <= {2'b10, addr_i, 1'b0};
          pins_r <= '{cs: 1'b1, sk: 1'b0, dout: 1'b1};
        end
      end else begin
        tick_r <= tick_end ? 16'h0000 : tick_r + 16'h0001;
        if (rise) begin
          pins_r.sk <= 1'b1;
          if (bit_r > 6'd9) begin
            data_r <= {data_r[14:0], din_i};
          end
        end
        if (fall) begin
          pins_r.sk <= 1'b0;
          bit_r <= bit_r + 6'h01;
          pins_r.dout <= cmd_r[8];
          cmd_r <= {cmd_r[7:0], 1'b0};
          if (bit_r == LAST_BIT) begin
            busy_r <= 1'b0;
            done_r <= 1'b1;
            pins_r <= '0;
          end
        end
      end
    end
  end

  assign pins_o = pins_r;
  assign busy_o = busy_r;
  assign done_o = done_r;
  assign data_o = data_r;
endmodule

// file: testbench/hcr_rom_model.sv
// Serial ROM partner: 64 x 16 words, read opcode 110, address MSB first.
// Assumes the block drives select, clock and data; data changes on clock fall.
`timescale 1ns/1ps
module hcr_rom_model (
  input wire logic cs_i, // chip select
  input wire logic sk_i, // serial clock
  input wire logic di_i, // data from block
  output logic do_o // data to block
);
  int cnt = 0;
  logic [5:0] addr = 6'h00;
  logic [15:0] q;
  function automatic logic [15:0] word(input logic [5:0] a);
    return {2'h2, a, 2'h1, a};
  endfunction
  assign q = word(addr);
  initial do_o = 1'b0;
  always @(posedge sk_i) begin
    if (cs_i) begin
      cnt <= cnt + 1;
      if (cnt >= 3 && cnt <= 8) begin
        addr <= {addr[4:0], di_i};
      end
    end
  end
  always @(negedge sk_i) begin
    if (cs_i && cnt >= 9 && cnt <= 25) begin
      do_o <= (cnt == 9) ? 1'b0 : q[25 - cnt];
    end
  end
  // Released line flips so a stale level never passes for data
  always @(negedge cs_i) begin
    cnt <= 0;
    do_o <= ~do_o;
  end
endmodule

// file: testbench/hcr_regs_sva.sv
// Port checker for the host configuration registers.
// Assumes one clock domain; bound to every hcr_regs instance.
`timescale 1ns/1ps
module hcr_regs_sva #(
  parameter int ROM_HALF_CYC = 1
) (
  input wire logic ref_clk_i, // clock
  input wire logic rst_n_i, // reset
  input wire logic clk_en_i, // enable
  input wire hcr_pkg::hcr_req_s req_i, // request
  input wire hcr_pkg::hcr_word_t rdata_o, // read data
  input wire logic rom_present_strap_i, // strap
  input wire logic rom_data_in_pin_i, // rom in
  input wire logic rom_data_out_pin_o, // rom out
  input wire logic rom_serial_clock_pin_o, // rom clock
  input wire logic rom_chip_select_pin_o, // rom select
  input wire hcr_pkg::hcr_selftest_s selftest_i, // self-test
  input wire hcr_pkg::hcr_word_t station_addr_low_word_o, // addr low
  input wire hcr_pkg::hcr_word_t base_addr_o, // base
  input wire hcr_pkg::hcr_speed_e internal_bus_speed_code_o, // speed
  input wire logic core_soft_reset_o, // soft reset
  input wire logic load_busy_o // loading
);
  import hcr_pkg::*;
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (!rst_n_i);
  wire go = clk_en_i && !load_busy_o && req_i.wr;
  wire w2 = go && req_i.bank == 2'h2;
  wire w3 = go && req_i.bank == 2'h3;
  wire r3 = clk_en_i && req_i.rd && req_i.bank == 2'h3;
  wire [2:0] pins = {rom_data_out_pin_o, rom_serial_clock_pin_o, rom_chip_select_pin_o};
  wire hcr_word_t st = {3'h0, selftest_i.tx_done, selftest_i.tx_fail, 6'h0,
    selftest_i.rx_done, selftest_i.rx_fail, 3'h0};
  sequence s_din_quiet;
    $stable(rom_data_in_pin_i) [*6];
  endsequence
  property p_low_wr;
    w2 && req_i.ofs == 3'h0 |=> station_addr_low_word_o == $past(req_i.wdata);
  endproperty
  a_low_wr: assert property (p_low_wr) else $error("low word write lost");
  property p_speed_wr;
    w3 && req_i.ofs == 3'h0 |=> internal_bus_speed_code_o == $past(req_i.wdata[1:0]);
  endproperty
  a_speed_wr: assert property (p_speed_wr) else $error("speed write lost");
  property p_soft_wr;
    w3 && req_i.ofs == 3'h6 |=> core_soft_reset_o == $past(req_i.wdata[0]);
  endproperty
  a_soft_wr: assert property (p_soft_wr) else $error("soft reset write lost");
  property p_base_kept;
    core_soft_reset_o |-> ##1 $stable(base_addr_o);
  endproperty
  a_base_kept: assert property (p_base_kept) else $error("base moved in soft reset");
  property p_selftest;
    r3 && req_i.ofs == 3'h4 |=> rdata_o == $past(st);
  endproperty
  a_selftest: assert property (p_selftest) else $error("self-test read wrong");
  property p_sw_pins;
    w3 && req_i.ofs == 3'h2 && req_i.wdata[4] |=> pins == $past(req_i.wdata[2:0]);
  endproperty
  a_sw_pins: assert property (p_sw_pins) else $error("pins not software driven");
  property p_cs_off;
    w3 && req_i.ofs == 3'h2 && !req_i.wdata[4] |=> !rom_chip_select_pin_o;
  endproperty
  a_cs_off: assert property (p_cs_off) else $error("select follows register");
  property p_din_rd;
    s_din_quiet ##0 ($past(rst_n_i, 8) && r3 && req_i.ofs == 3'h2)
      |=> rdata_o[3] == $past(rom_data_in_pin_i);
  endproperty
  a_din_rd: assert property (p_din_rd) else $error("data in bit wrong");
  property p_rst_vals;
    $rose(rst_n_i) && !rom_present_strap_i |-> internal_bus_speed_code_o == HCR_SPD_125
      && base_addr_o == 16'h0300 && pins == 3'h0 && !core_soft_reset_o;
  endproperty
  a_rst_vals: assert property (p_rst_vals) else $error("reset values wrong");
endmodule
bind hcr_regs hcr_regs_sva #(.ROM_HALF_CYC(ROM_HALF_CYC)) u_hcr_regs_sva (
  .ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .clk_en_i(clk_en_i), .req_i(req_i),
  .rdata_o(rdata_o), .rom_present_strap_i(rom_present_strap_i),
  .rom_data_in_pin_i(rom_data_in_pin_i), .rom_data_out_pin_o(rom_data_out_pin_o),
  .rom_serial_clock_pin_o(rom_serial_clock_pin_o),
  .rom_chip_select_pin_o(rom_chip_select_pin_o), .selftest_i(selftest_i),
  .station_addr_low_word_o(station_addr_low_word_o), .base_addr_o(base_addr_o),
  .internal_bus_speed_code_o(internal_bus_speed_code_o),
  .core_soft_reset_o(core_soft_reset_o), .load_busy_o(load_busy_o)
);

// file: testbench/hcr_regs_test.sv
// Self-checking bench for the register banks with a serial ROM partner.
// Assumes the checker binds itself; ROM half period shortened to 5 cycles,
// the least that still lets read data cross the data-in synchroniser.
`timescale 1ns/1ps
module hcr_regs_test;
  import hcr_pkg::*;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic strap = 1'b0;
  logic din, dout, sk, cs, srst, busy;
  hcr_req_s req = '0;
  hcr_selftest_s st = '0;
  hcr_word_t rdata, lo, mid, hi, base, v;
  hcr_speed_e spd;
  int errors = 0;
  int comparisons = 0;
  always #50 clk = ~clk;
  hcr_regs #(.ROM_HALF_CYC(5)) u_hcr_regs (
    .ref_clk_i(clk), .rst_n_i(rst_n), .clk_en_i(1'b1), .req_i(req), .rdata_o(rdata),
    .rom_present_strap_i(strap), .rom_data_in_pin_i(din), .rom_data_out_pin_o(dout),
    .rom_serial_clock_pin_o(sk), .rom_chip_select_pin_o(cs), .selftest_i(st),
    .station_addr_low_word_o(lo), .station_addr_mid_word_o(mid),
    .station_addr_high_word_o(hi), .base_addr_o(base),
    .internal_bus_speed_code_o(spd), .core_soft_reset_o(srst), .load_busy_o(busy)
  );
  hcr_rom_model u_hcr_rom_model (.cs_i(cs), .sk_i(sk), .di_i(dout), .do_o(din));
  function automatic hcr_word_t rom_word(input logic [5:0] a);
    return {2'h2, a, 2'h1, a};
  endfunction
  task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      errors++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic wr(input logic [1:0] b, input logic [2:0] o, input hcr_word_t d);
    req = '{1'b0, 1'b1, b, o, d};
    cyc(1);
    req.wr = 1'b0;
    cyc(1);
  endtask
  task automatic rd(input logic [1:0] b, input logic [2:0] o);
    req = '{1'b1, 1'b0, b, o, 16'h0};
    cyc(1);
    req.rd = 1'b0;
    cyc(1);
    v = rdata;
  endtask
  task automatic rst(input logic s);
    rst_n = 1'b0;
    strap = s;
    cyc(5);
    rst_n = 1'b1;
  endtask
  task automatic print_verdict;
    if (errors == 0 && comparisons > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  task automatic t_reset;
    chk("base", base, 16'h0300);
    chk("speed", {14'h0, spd}, 16'h0000);
    chk("pins", {13'h0, dout, sk, cs}, 16'h0000);
    rd(2'h3, 3'h2);
    chk("rom ctrl", v & 16'hfff7, 16'h0000);
    rd(2'h3, 3'h6);
    chk("soft reg", v, 16'h0000);
  endtask
  task automatic t_addr;
    wr(2'h2, 3'h0, 16'h89ab);
    wr(2'h2, 3'h2, 16'h4567);
    wr(2'h2, 3'h4, 16'h0123);
    chk("low", lo, 16'h89ab);
    chk("mid", mid, 16'h4567);
    chk("high", hi, 16'h0123);
    rd(2'h2, 3'h4);
    chk("high read", v, 16'h0123);
    rd(2'h2, 3'h6);
    chk("unmapped", v, 16'h0000);
  endtask
  task automatic t_speed;
    for (int c = 0; c < 4; c++) begin
      wr(2'h3, 3'h0, 16'hfffc | 16'(c));
      rd(2'h3, 3'h0);
      chk("speed reg", v, 16'(c));
      chk("speed out", {14'h0, spd}, 16'(c));
    end
  endtask
  task automatic t_selftest;
    for (int p = 0; p < 16; p++) begin
      st = hcr_selftest_s'(p[3:0]);
      rd(2'h3, 3'h4);
      chk("selftest", v, {3'h0, st.tx_done, st.tx_fail, 6'h0, st.rx_done, st.rx_fail, 3'h0});
    end
  endtask
  task automatic t_soft;
    wr(2'h3, 3'h6, 16'hffff);
    chk("soft on", srst, 16'h0001);
    rd(2'h3, 3'h6);
    chk("soft reg", v, 16'h0001);
    chk("base kept", base, 16'h0300);
    wr(2'h3, 3'h6, 16'h0000);
    chk("soft off", srst, 16'h0000);
  endtask
  // Software times a whole word read by hand through the control bits
  task automatic t_sw_rom;
    logic [8:0] cmd;
    hcr_word_t got, ctl;
    cmd = 9'b110000001;
    got = 16'h0;
    for (int i = 0; i < 26; i++) begin
      ctl = {11'h0, 1'b1, 1'b0, (i < 9) ? cmd[8 - i] : 1'b0, 2'b01};
      wr(2'h3, 3'h2, ctl);
      wr(2'h3, 3'h2, ctl | 16'h0002);
      cyc(5);
      rd(2'h3, 3'h2);
      chk("rom ctrl", v & 16'hfff7, ctl | 16'h0002);
      chk("pins", {13'h0, dout, sk, cs}, 16'(ctl[2:0] | 3'h2));
      chk("data in", v[3], din);
      got = (i >= 10) ? {got[14:0], v[3]} : got;
    end
    chk("rom word", got, rom_word(6'h01));
    wr(2'h3, 3'h2, 16'h0007);
    chk("select", cs, 16'h0000);
  endtask
  task automatic t_load;
    rst(1'b1);
    cyc(2);
    for (int n = 0; n < 3000 && busy !== 1'b0; n++) begin
      cyc(1);
    end
    chk("loaded", busy, 16'h0000);
    chk("base", base, rom_word(6'h00) & 16'hffe0);
    chk("low", lo, rom_word(6'h01));
    chk("mid", mid, rom_word(6'h02));
    chk("high", hi, rom_word(6'h03));
    chk("speed", {14'h0, spd}, 16'h0003);
    wr(2'h3, 3'h0, 16'h0001);
    chk("speed later", {14'h0, spd}, 16'h0001);
  endtask
  initial begin
    rst(1'b0);
    cyc(2);
    t_reset;
    t_addr;
    t_speed;
    t_selftest;
    t_soft;
    t_sw_rom;
    t_load;
    print_verdict;
  end
  initial begin
    #2000000;
    errors++;
    print_verdict;
  end
endmodule
